//--- bpsp_assertions.sv
`timescale 1ns/1ns
module bpsp_checker
   import bpsp_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // pins and event
   input wire logic [7:0] byte_pin_in,
   input wire logic [7:0] byte_pin_out,
   input wire logic [7:0] byte_pin_oe_n,
   input wire logic [2:0] ctl_pin_in,
   input wire logic [2:0] ctl_pin_out,
   input wire logic [2:0] ctl_pin_oe_n,
   input wire logic       slave_port_interrupt_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // read data stand one cycle only, so software never sees stale bytes
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property ($past(reg_rd && reg_addr == 8'h00)
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_reset_levels: assert property ($rose(rst_n)
      |-> byte_pin_oe_n == 8'hFF && ctl_pin_oe_n == 3'h7)
      else $error("pins driven after reset");
   a_irq_pulse: assert property (slave_port_interrupt_flag
      |=> !slave_port_interrupt_flag) else $error("event longer than one");
   // event only after the strobes have settled through the sync
   a_irq_after_end: assert property (slave_port_interrupt_flag
      |-> $past(ctl_pin_in[2] || &ctl_pin_in[1:0], 3))
      else $error("event before access end");
   a_dir_by_write: assert property ($changed(ctl_pin_oe_n)
      |-> $past(reg_wr && reg_addr == BPSP_ADDR_SP_CS))
      else $error("control enables moved alone");
   a_latch_by_write: assert property ($changed(byte_pin_out)
      |-> $past(reg_wr && reg_addr == BPSP_ADDR_BYTE_DATA))
      else $error("byte latch moved alone");
   a_ctl_latch: assert property ($changed(ctl_pin_out)
      |-> $past(reg_wr && reg_addr == BPSP_ADDR_CTL_DATA))
      else $error("control latch moved alone");
   // main scenarios
   cover property (slave_port_interrupt_flag);
   cover property (byte_pin_oe_n == 8'h00 && ctl_pin_oe_n == 3'h7);
   cover property ($past(reg_rd) && reg_rdata[BPSP_IBF_BIT]);
endmodule
bind bpsp_top bpsp_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .byte_pin_in, .byte_pin_out,
   .byte_pin_oe_n, .ctl_pin_in, .ctl_pin_out, .ctl_pin_oe_n,
   .slave_port_interrupt_flag);

//--- bpsp_host_model.sv
`timescale 1ns/1ns
module bpsp_host_model
(
   // clock
   input wire logic       clk,
   // device side of the pins
   input wire logic [7:0] byte_pin_out,
   input wire logic [7:0] byte_pin_oe_n,
   input wire logic [2:0] ctl_pin_out,
   input wire logic [2:0] ctl_pin_oe_n,
   // resolved pin levels
   output logic     [7:0] byte_pin_in,
   output logic     [2:0] ctl_pin_in
);
   logic [7:0] host_q;
   logic       host_drv;
   logic [2:0] host_ctl;
   initial begin
      host_q = 8'h00;
      host_drv = 1'b0;
      host_ctl = 3'h7;
   end
   // a released bus shows the inverse of its last value, never a copy
   assign byte_pin_in = (byte_pin_oe_n & (host_drv ? host_q : ~host_q))
                      | (~byte_pin_oe_n & byte_pin_out);
   assign ctl_pin_in = (ctl_pin_oe_n & host_ctl) | (~ctl_pin_oe_n & ctl_pin_out);
   // strobes held 4 clk low and 12 high so the sync always sees them
   task automatic ext_write(input logic [7:0] d, input logic sel);
      @(posedge clk);
      host_q <= d;
      host_drv <= 1'b1;
      host_ctl <= {~sel, 2'b01};
      repeat (4) @(posedge clk);
      host_ctl <= 3'h7;
      repeat (2) @(posedge clk);
      host_drv <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   // returns bus level and enables seen in mid-strobe
   task automatic ext_read(output logic [7:0] d, output logic [7:0] oe);
      @(posedge clk);
      host_ctl <= 3'b010;
      repeat (4) @(posedge clk);
      #1 d = byte_pin_in;
      oe = byte_pin_oe_n;
      @(posedge clk);
      host_ctl <= 3'h7;
      repeat (12) @(posedge clk);
   endtask
endmodule

//--- bpsp_phase.sv
`timescale 1ns/1ns
module bpsp_phase
   import bpsp_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // phase enables, one clk each per instruction cycle
   output logic      q2_en,
   output logic      q4_en
);
   logic [1:0] ph_r;

   // free-running q1..q4 divider
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ph_r <= 2'h0;
      else        ph_r <= ph_r + 2'h1;
   end

   assign q2_en = (ph_r == BPSP_PH_Q2);
   assign q4_en = (ph_r == BPSP_PH_Q4);
endmodule

//--- bpsp_pkg.sv
package bpsp_pkg;
   // register offsets
   localparam logic [7:0] BPSP_ADDR_BYTE_DATA = 8'h08;
   localparam logic [7:0] BPSP_ADDR_CTL_DATA  = 8'h09;
   localparam logic [7:0] BPSP_ADDR_BYTE_DIR  = 8'h88;
   localparam logic [7:0] BPSP_ADDR_SP_CS     = 8'h89;
   localparam logic [7:0] BPSP_ADDR_APC       = 8'h9F;
   // slave_port_control_status fields
   localparam int BPSP_IBF_BIT  = 7;
   localparam int BPSP_OBF_BIT  = 6;
   localparam int BPSP_OVF_BIT  = 5;
   localparam int BPSP_MODE_BIT = 4;
   localparam logic [2:0] BPSP_CTL_DIR_RST = 3'h7;
   localparam logic [7:0] BPSP_BYTE_DIR_RST = 8'hFF;
   localparam logic [7:0] BPSP_APC_RST      = 8'h00;
   localparam logic [7:0] BPSP_APC_MASK     = 8'h8F;
   localparam logic [7:0] BPSP_LATCH_RST    = 8'h00;
   // control pins are digital when field[3:1] matches this
   localparam logic [2:0] BPSP_APC_DIGITAL  = 3'h3;
   // control pin numbering
   localparam int BPSP_PIN_RD = 0;
   localparam int BPSP_PIN_WR = 1;
   localparam int BPSP_PIN_CS = 2;
   // instruction cycle phases: phase codes of q2 and q4
   localparam logic [1:0] BPSP_PH_Q2 = 2'h1;
   localparam logic [1:0] BPSP_PH_Q4 = 2'h3;
   // completion sequencer states
   typedef enum logic [1:0] {BPSP_IDLE, BPSP_WAIT_Q2, BPSP_WAIT_Q4}
      bpsp_done_t;
endpackage

//--- bpsp_sync.sv
`timescale 1ns/1ns
module bpsp_sync
   import bpsp_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // raw and synchronised strobes
   input  wire logic [2:0] raw,
   output logic      [2:0] synced
);
   logic [2:0] meta_r;

   // two flops; idle level of strobes is high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 3'h7;
         synced <= 3'h7;
      end else begin
         meta_r <= raw;
         synced <= meta_r;
      end
   end
endmodule

//--- bpsp_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module bpsp_top
   import bpsp_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // byte port pins
   input  wire logic [7:0] byte_pin_in,
   output logic      [7:0] byte_pin_out,
   output logic      [7:0] byte_pin_oe_n,
   // control pins: read strobe, write strobe, chip select
   input  wire logic [2:0] ctl_pin_in,
   output logic      [2:0] ctl_pin_out,
   output logic      [2:0] ctl_pin_oe_n,
   // completion event for an external interrupt controller
   output logic            slave_port_interrupt_flag
);
   import bpsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] out_latch_r;
   logic [7:0] in_latch_r;
   logic [7:0] byte_dir_r;
   logic [2:0] ctl_latch_r;
   logic [2:0] ctl_dir_r;
   logic       mode_r;
   logic       ibf_r;
   logic       obf_r;
   logic       ovf_r;
   logic [7:0] apc_r;
   logic [7:0] rdata_nxt;
   logic       wr_act_r;
   logic       rd_act_r;
   logic       done_r;
   bpsp_done_t done_st_r [2];
   logic [1:0] done_set;

   ////////////////////////////////////////////////////////////////////////
   // strobe synchronisation and phase enables
   logic [2:0] ctl_s;
   logic       q2_en;
   logic       q4_en;

   bpsp_sync u_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .raw    (ctl_pin_in),
      .synced (ctl_s)
   );

   bpsp_phase u_phase (
      .clk   (clk),
      .rst_n (rst_n),
      .q2_en (q2_en),
      .q4_en (q4_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire sel_byte_data = (reg_addr == BPSP_ADDR_BYTE_DATA);
   wire sel_ctl_data  = (reg_addr == BPSP_ADDR_CTL_DATA);
   wire sel_byte_dir  = (reg_addr == BPSP_ADDR_BYTE_DIR);
   wire sel_sp_cs     = (reg_addr == BPSP_ADDR_SP_CS);
   wire sel_apc       = (reg_addr == BPSP_ADDR_APC);

   wire wr_byte_data  = reg_wr & sel_byte_data;
   wire rd_byte_data  = reg_rd & sel_byte_data;
   wire wr_sp_cs      = reg_wr & sel_sp_cs;

   // reset value of analog field leaves control pins analog
   wire ctl_digital = (apc_r[3:1] == BPSP_APC_DIGITAL);

   // slave access decode on synchronised levels
   wire cs_on   = mode_r & ~ctl_s[BPSP_PIN_CS];
   wire wr_on   = cs_on & ~ctl_s[BPSP_PIN_WR];
   wire rd_on   = cs_on & ~ctl_s[BPSP_PIN_RD];
   wire wr_beg  = wr_on & ~wr_act_r;
   wire wr_end  = ~wr_on & wr_act_r;
   wire rd_beg  = rd_on & ~rd_act_r;
   wire rd_end  = ~rd_on & rd_act_r;
   wire [1:0] end_evt = {rd_end, wr_end};

   ////////////////////////////////////////////////////////////////////////
   // byte port pins
   // read drive uses raw pins so the bus sees data without sync delay
   wire raw_read = mode_r & ~ctl_pin_in[BPSP_PIN_CS]
                 & ~ctl_pin_in[BPSP_PIN_RD];
   assign byte_pin_out  = out_latch_r;
   assign byte_pin_oe_n = mode_r ? {8{~raw_read}} : byte_dir_r;

   // control pins never driven in slave mode
   assign ctl_pin_out  = ctl_latch_r;
   assign ctl_pin_oe_n = mode_r ? 3'h7 : ctl_dir_r;

   ////////////////////////////////////////////////////////////////////////
   // read mux
   wire [7:0] byte_rd_val = mode_r ? in_latch_r : byte_pin_in;
   wire [2:0] ctl_rd_val  = ctl_digital ? ctl_pin_in : 3'h0;
   wire [7:0] sp_cs_val   = {ibf_r, obf_r, ovf_r, mode_r,
                             1'b0, ctl_dir_r};

   always_comb begin
      rdata_nxt = 8'h00;
      if (sel_byte_data)     rdata_nxt = byte_rd_val;
      else if (sel_ctl_data) rdata_nxt = {5'h00, ctl_rd_val};
      else if (sel_byte_dir) rdata_nxt = byte_dir_r;
      else if (sel_sp_cs)    rdata_nxt = sp_cs_val;
      else if (sel_apc)      rdata_nxt = apc_r;
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)      reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rdata_nxt;
      else             reg_rdata <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // software-written configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_latch_r <= BPSP_LATCH_RST;
         byte_dir_r  <= BPSP_BYTE_DIR_RST;
         ctl_latch_r <= 3'h0;
         ctl_dir_r   <= BPSP_CTL_DIR_RST;
         mode_r      <= 1'b0;
         apc_r       <= BPSP_APC_RST;
      end else begin
         if (wr_byte_data) out_latch_r <= reg_wdata;
         if (reg_wr & sel_byte_dir) byte_dir_r <= reg_wdata;
         if (reg_wr & sel_ctl_data) ctl_latch_r <= reg_wdata[2:0];
         if (wr_sp_cs) begin
            mode_r    <= reg_wdata[BPSP_MODE_BIT];
            ctl_dir_r <= reg_wdata[2:0];
         end
         if (reg_wr & sel_apc) apc_r <= reg_wdata & BPSP_APC_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slave access tracking and input latch
   // data keeps loading while the write is active, so the value
   // present when the synchronised strobe rises is the one held
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_act_r   <= 1'b0;
         rd_act_r   <= 1'b0;
         in_latch_r <= BPSP_LATCH_RST;
      end else begin
         wr_act_r <= wr_on;
         rd_act_r <= rd_on;
         if (wr_on) in_latch_r <= byte_pin_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // completion: q4 following the next q2 after an access ends
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_done
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               done_st_r[g] <= BPSP_IDLE;
            end else begin
               case (done_st_r[g])
                  BPSP_IDLE: begin
                     if (end_evt[g]) done_st_r[g] <= BPSP_WAIT_Q2;
                  end
                  BPSP_WAIT_Q2: begin
                     if (q2_en) done_st_r[g] <= BPSP_WAIT_Q4;
                  end
                  BPSP_WAIT_Q4: begin
                     if (q4_en) done_st_r[g] <= BPSP_IDLE;
                  end
                  default: done_st_r[g] <= BPSP_IDLE;
               endcase
            end
         end
         assign done_set[g] = (done_st_r[g] == BPSP_WAIT_Q4) & q4_en;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // status flags; a hardware set always beats a same-cycle clear
   wire ibf_set = done_set[0] & mode_r;
   wire ibf_clr = rd_byte_data;
   wire obf_set = wr_byte_data;
   wire ovf_set = wr_beg & ibf_r;
   wire ovf_clr = wr_sp_cs & ~reg_wdata[BPSP_OVF_BIT];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ibf_r <= 1'b0;
         obf_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         if (!mode_r)      ibf_r <= 1'b0;
         else if (ibf_set) ibf_r <= 1'b1;
         else if (ibf_clr) ibf_r <= 1'b0;
         // read start wins: the bus has already taken the byte
         if (!mode_r)      obf_r <= 1'b0;
         else if (rd_beg)  obf_r <= 1'b0;
         else if (obf_set) obf_r <= 1'b1;
         // overflow survives leaving slave mode only if that control/status write keeps bit 5 set
         if (ovf_set)      ovf_r <= 1'b1;
         else if (ovf_clr) ovf_r <= 1'b0;
      end
   end

   // one-cycle completion pulse for reads and writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) done_r <= 1'b0;
      else        done_r <= |done_set;
   end
   assign slave_port_interrupt_flag = done_r;
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
   import bpsp_pkg::*;
   logic       clk, rst_n, reg_wr, reg_rd, irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, byte_pin_in, byte_pin_out;
   logic [7:0] byte_pin_oe_n, rd_d, oe_d;
   logic [2:0] ctl_pin_in, ctl_pin_out, ctl_pin_oe_n;
   int         mismatches, n_compared, n_irq;
   ////////////////////////////////////////////////////////////////////////
   always #25 clk = ~clk;
   // count completion events; each selected slave access must give exactly one
   always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;
   bpsp_top u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .byte_pin_in, .byte_pin_out, .byte_pin_oe_n, .ctl_pin_in,
      .ctl_pin_out, .ctl_pin_oe_n, .slave_port_interrupt_flag(irq));
   bpsp_host_model u_host (.clk, .byte_pin_out, .byte_pin_oe_n,
      .ctl_pin_out, .ctl_pin_oe_n, .byte_pin_in, .ctl_pin_in);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_rc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic end_of_test;
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      reg_rc(BPSP_ADDR_SP_CS, 8'h07);
      reg_rc(BPSP_ADDR_APC, 8'h00);
      reg_rc(8'h00, 8'h00);
      reg_w(BPSP_ADDR_SP_CS, 8'hE8);
      reg_rc(BPSP_ADDR_SP_CS, 8'h00);
      chk({5'h00, ctl_pin_oe_n}, 8'h00);
      reg_w(BPSP_ADDR_CTL_DATA, 8'h05);
      reg_rc(BPSP_ADDR_CTL_DATA, 8'h00);
      reg_w(BPSP_ADDR_APC, 8'h06);
      reg_rc(BPSP_ADDR_CTL_DATA, 8'h05);
      reg_w(BPSP_ADDR_SP_CS, 8'h07);
   endtask
   // upper nibble driven, lower released and read back inverted
   task automatic t_gpio;
      reg_w(BPSP_ADDR_BYTE_DIR, 8'h0F);
      reg_w(BPSP_ADDR_BYTE_DATA, 8'hA5);
      #1 chk(byte_pin_oe_n, 8'h0F);
      reg_rc(BPSP_ADDR_BYTE_DATA, 8'hAF);
   endtask
   task automatic t_slave_write;
      reg_w(BPSP_ADDR_SP_CS, 8'h17);
      #1 chk({5'h00, ctl_pin_oe_n}, 8'h07);
      chk(byte_pin_oe_n, 8'hFF);
      u_host.ext_write(8'h3C, 1'b1);
      reg_rc(BPSP_ADDR_SP_CS, 8'h97);
      u_host.ext_write(8'hC3, 1'b1);
      reg_rc(BPSP_ADDR_SP_CS, 8'hB7);
      reg_rc(BPSP_ADDR_BYTE_DATA, 8'hC3);
      reg_rc(BPSP_ADDR_SP_CS, 8'h37);
      reg_w(BPSP_ADDR_SP_CS, 8'h17);
      reg_rc(BPSP_ADDR_SP_CS, 8'h17);
      chk(8'(n_irq), 8'h02);
   endtask
   task automatic t_slave_read;
      reg_w(BPSP_ADDR_BYTE_DATA, 8'h5A);
      reg_rc(BPSP_ADDR_SP_CS, 8'h57);
      u_host.ext_read(rd_d, oe_d);
      chk(rd_d, 8'h5A);
      chk(oe_d, 8'h00);
      reg_rc(BPSP_ADDR_SP_CS, 8'h17);
      chk(8'(n_irq), 8'h03);
   endtask
   task automatic t_deselect;
      u_host.ext_write(8'h99, 1'b0);
      reg_rc(BPSP_ADDR_SP_CS, 8'h17);
      chk(8'(n_irq), 8'h03);
      reg_w(BPSP_ADDR_BYTE_DATA, 8'h11);
      reg_w(BPSP_ADDR_SP_CS, 8'h07);
      reg_rc(BPSP_ADDR_SP_CS, 8'h07);
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      mismatches = 0;
      n_compared = 0;
      n_irq = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_gpio();
      t_slave_write();
      t_slave_read();
      t_deselect();
      end_of_test();
   end
endmodule
